// [src/capture_timer.sv]
// Capture timer core: APB registers, counter modes, events, interrupt and sleep
`timescale 1ns/1ps
module capture_timer (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Companion timer
  input  wire logic        companionTick,
  input  wire logic        companionRestart,
  // Event input and output
  input  wire logic        eventIn,
  output logic             captureEvent,
  // Power state
  input  wire logic        standbySleep,
  input  wire logic        powerDownSleep,
  input  wire logic        debugHalt,
  // Waveform and interrupt
  output logic             waveOut,
  output logic             irq
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Local alias of the package enum, declared before its first use
  typedef capture_timer_pkg::fp_state_t seq_state_t;
  logic [7:0]  controlA_q, controlB_q, eventCtl_q, intEnable_q, dbgCtl_q, byteBuf_q;
  logic        flag_q;
  logic [15:0] count_q, count_d;
  logic [15:0] compare_q, compare_d;
  logic        running_q, running_d;
  logic        wave_q, wave_d;
  logic        div2_q;
  logic        fpSecond_q, fpSecond_d;
  seq_state_t  fpState_q, fpState_d;
  logic        trigPend_q;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire [7:0] regIdx   = paddr[9:2];
  wire       upperHit = |paddr[11:10];
  wire       access   = psel & penable & pready;
  wire       wrDone   = access & pwrite;
  wire       rdDone   = access & ~pwrite;
  wire       lane0    = pstrb[0];
  wire       lane1    = pstrb[1];

  function automatic logic hit(input logic [7:0] idx, input logic [7:0] want, input logic hi);
    hit = (idx == want) & ~hi;
  endfunction : hit

  wire selCa   = hit(regIdx, capture_timer_pkg::IDX_CONTROL_A, upperHit);
  wire selCb   = hit(regIdx, capture_timer_pkg::IDX_CONTROL_B, upperHit);
  wire selRes  = hit(regIdx, capture_timer_pkg::IDX_RESERVED_0, upperHit)
               | hit(regIdx, capture_timer_pkg::IDX_RESERVED_1, upperHit);
  wire selEv   = hit(regIdx, capture_timer_pkg::IDX_EVENT_CONTROL, upperHit);
  wire selIe   = hit(regIdx, capture_timer_pkg::IDX_INTERRUPT_ENABLE, upperHit);
  wire selIf   = hit(regIdx, capture_timer_pkg::IDX_INTERRUPT_FLAG, upperHit);
  wire selSt   = hit(regIdx, capture_timer_pkg::IDX_RUN_STATUS, upperHit);
  wire selDbg  = hit(regIdx, capture_timer_pkg::IDX_DEBUG_CONTROL, upperHit);
  wire selBuf  = hit(regIdx, capture_timer_pkg::IDX_BYTE_BUFFER, upperHit);
  wire selCnt  = hit(regIdx, capture_timer_pkg::IDX_COUNTER_VALUE, upperHit);
  wire selCmp  = hit(regIdx, capture_timer_pkg::IDX_COMPARE_CAPTURE, upperHit);
  wire mapped  = selCa | selCb | selRes | selEv | selIe | selIf | selSt
               | selDbg | selBuf | selCnt | selCmp;

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  wire         enable     = controlA_q[capture_timer_pkg::CA_ENABLE_BIT];
  wire [1:0]   clkSource  = controlA_q[capture_timer_pkg::CA_CLOCK_SOURCE_SELECT_LSB +: 2];
  wire         restartCo  = controlA_q[capture_timer_pkg::CA_RESTART_BIT];
  wire         runStandby = controlA_q[capture_timer_pkg::CA_STANDBY_BIT];
  wire [2:0]   modeBits   = controlB_q[capture_timer_pkg::CB_MODE_LSB +: 3];
  wire         outEnable  = controlB_q[capture_timer_pkg::CB_OUT_EN_BIT];
  wire         outInit    = controlB_q[capture_timer_pkg::CB_OUT_INIT_BIT];
  wire         asyncTrig  = controlB_q[capture_timer_pkg::CB_ASYNCHRONOUS_TRIGGER_BIT];
  wire         evEnable   = eventCtl_q[capture_timer_pkg::EV_INPUT_EN_BIT];
  wire         evEdge     = eventCtl_q[capture_timer_pkg::EV_EDGE_BIT];
  wire         evFilter   = eventCtl_q[capture_timer_pkg::EV_FILTER_BIT];
  wire         run_while_halted_debug     = dbgCtl_q[capture_timer_pkg::DBG_RUN_BIT];
  capture_timer_pkg::timer_mode_t mode;
  assign mode = capture_timer_pkg::timer_mode_t'(modeBits);

  // ----------------------------------------------------------------
  // Sleep gating
  // ----------------------------------------------------------------
  // Power-down wins over everything; standby halts unless allowed
  wire halted = powerDownSleep
              | (standbySleep & ~runStandby)
              | (debugHalt & ~run_while_halted_debug);
  wire active = enable & ~halted;

  // ----------------------------------------------------------------
  // Count tick selection
  // ----------------------------------------------------------------
  wire srcTick = (clkSource == capture_timer_pkg::CLKSRC_DIV1) ? 1'b1 :
                 (clkSource == capture_timer_pkg::CLKSRC_DIV2) ? div2_q :
                 companionTick;
  wire tick    = active & srcTick;
  wire coRestart = active & restartCo & companionRestart;

  // ----------------------------------------------------------------
  // Event input
  // ----------------------------------------------------------------
  logic riseEdge, fallEdge;

  event_edge_sync u_edge (
    .clk      (clk),
    .nrst     (nrst),
    .eventIn  (eventIn),
    .filterOn (evFilter),
    .riseEdge (riseEdge),
    .fallEdge (fallEdge)
  );

  // Primary edge follows the edge-select bit, secondary is the other one
  wire evLive  = active & evEnable;
  wire primEv  = evLive & (evEdge ? fallEdge : riseEdge);
  wire secEv   = evLive & (evEdge ? riseEdge : fallEdge);
  wire anyEv   = evLive & (riseEdge | fallEdge);
  // Single-shot: edge bit set means any edge starts the shot
  wire shotEv  = evEdge ? anyEv : (evLive & riseEdge);

  wire atTop    = (count_q == compare_q);
  wire atPwmTop = (count_q[7:0] == compare_q[7:0]);
  wire capMode  = (mode == capture_timer_pkg::MODE_CAPTURE) | (mode == capture_timer_pkg::MODE_FREQ)
                | (mode == capture_timer_pkg::MODE_PULSE) | (mode == capture_timer_pkg::MODE_FREQPULSE);

  // ----------------------------------------------------------------
  // Mode engine
  // ----------------------------------------------------------------
  logic setFlag;

  always_comb begin
    count_d    = count_q;
    compare_d  = compare_q;
    running_d  = running_q;
    wave_d     = wave_q;
    fpState_d  = fpState_q;
    fpSecond_d = fpSecond_q;
    setFlag    = 1'b0;
    if (!enable) begin
      running_d = 1'b0;
      wave_d    = (mode == capture_timer_pkg::MODE_SINGLE || mode == capture_timer_pkg::MODE_PWM8)
                  ? 1'b0 : outInit;
      fpState_d = capture_timer_pkg::FP_WAIT_RISE;
    end else if (active) begin
      case (mode)
        capture_timer_pkg::MODE_PERIODIC: begin
          running_d = 1'b1;
          if (tick) begin
            count_d = atTop ? capture_timer_pkg::RESET_WORD : count_q + 16'h0001;
            setFlag = atTop;
          end
        end
        capture_timer_pkg::MODE_TIMEOUT: begin
          if (primEv) begin
            running_d = 1'b1;
            count_d   = capture_timer_pkg::RESET_WORD;
          end else if (secEv) begin
            running_d = 1'b0;
          end else if (tick && running_q) begin
            count_d = count_q + 16'h0001;
            setFlag = atTop;
          end
        end
        capture_timer_pkg::MODE_CAPTURE: begin
          running_d = 1'b1;
          if (primEv) begin
            compare_d = count_q;
            setFlag   = 1'b1;
          end
          if (tick) count_d = count_q + 16'h0001;
        end
        capture_timer_pkg::MODE_FREQ: begin
          running_d = 1'b1;
          if (primEv) begin
            compare_d = count_q;
            count_d   = capture_timer_pkg::RESET_WORD;
            setFlag   = 1'b1;
          end else if (tick) begin
            count_d = count_q + 16'h0001;
          end
        end
        capture_timer_pkg::MODE_PULSE: begin
          running_d = 1'b1;
          if (primEv) begin
            count_d = capture_timer_pkg::RESET_WORD;
          end else if (secEv) begin
            compare_d = count_q;
            setFlag   = 1'b1;
          end else if (tick) begin
            count_d = count_q + 16'h0001;
          end
        end
        capture_timer_pkg::MODE_FREQPULSE: begin
          case (fpState_q)
            capture_timer_pkg::FP_WAIT_RISE: begin
              if (primEv) begin
                count_d   = capture_timer_pkg::RESET_WORD;
                running_d = 1'b1;
                fpState_d = capture_timer_pkg::FP_WAIT_FALL;
              end
            end
            capture_timer_pkg::FP_WAIT_FALL: begin
              if (secEv) begin
                compare_d = count_q;
                fpState_d = capture_timer_pkg::FP_WAIT_RISE2;
              end
            end
            capture_timer_pkg::FP_WAIT_RISE2: begin
              if (primEv) begin
                running_d = 1'b0;
                setFlag   = 1'b1;
                fpState_d = capture_timer_pkg::FP_DONE;
              end
            end
            default: begin
              if (!flag_q) fpState_d = capture_timer_pkg::FP_WAIT_RISE;
            end
          endcase
          if (tick && running_d && fpState_q != capture_timer_pkg::FP_WAIT_RISE2)
            count_d = count_q + 16'h0001;
          else if (tick && running_q && fpState_q == capture_timer_pkg::FP_WAIT_RISE2 && !primEv)
            count_d = count_q + 16'h0001;
        end
        capture_timer_pkg::MODE_SINGLE: begin
          // Asynchronous_trigger: output rises with the trigger, sync: one cycle after the trigger
          if (!running_q && (shotEv || trigPend_q) && !fpSecond_q) begin
            count_d   = capture_timer_pkg::RESET_WORD;
            running_d = 1'b1;
            wave_d    = 1'b1;
          end else if (running_q && tick) begin
            if (atTop) begin
              running_d  = 1'b0;
              wave_d     = 1'b0;
              setFlag    = 1'b1;
              fpSecond_d = 1'b1;
            end else begin
              count_d = count_q + 16'h0001;
            end
          end else if (fpSecond_q && tick) begin
            // Output stays low for at least one count tick; events ignored
            fpSecond_d = 1'b0;
          end
        end
        default: begin
          running_d = 1'b1;
          if (tick) begin
            count_d = atPwmTop ? capture_timer_pkg::RESET_WORD : count_q + 16'h0001;
            setFlag = atPwmTop;
            wave_d  = atPwmTop ? 1'b1 : ((count_q[7:0] + 8'h01) == compare_q[15:8]) ? 1'b0 : wave_q;
          end
        end
      endcase
      if (coRestart) count_d = capture_timer_pkg::RESET_WORD;
    end
    if (wrDone && selCnt) begin
      if (lane0) count_d[7:0]  = pwdata[7:0];
      if (lane1) count_d[15:8] = pwdata[15:8];
    end
    if (wrDone && selCmp) begin
      if (lane0) compare_d[7:0]  = pwdata[7:0];
      if (lane1) compare_d[15:8] = pwdata[15:8];
    end
  end

  // Sync single-shot start lags the trigger by one more cycle
  wire trigPend_d = (mode == capture_timer_pkg::MODE_SINGLE) & ~asyncTrig & shotEv
                  & ~running_q & ~fpSecond_q;
  wire syncStart  = ~asyncTrig & trigPend_q;
  wire asyncStart = asyncTrig & shotEv;
  wire shotGo     = (mode != capture_timer_pkg::MODE_SINGLE) | syncStart | asyncStart | running_q;

  // ----------------------------------------------------------------
  // Interrupt flag: set wins over every clear
  // ----------------------------------------------------------------
  wire cmpLowRead = rdDone & selCmp & capMode;
  wire flagClear  = (rdDone & selIf)
                  | (wrDone & selIf & lane0 & pwdata[capture_timer_pkg::FLAG_CAPTURE_BIT])
                  | cmpLowRead;
  wire flagSet    = setFlag & shotGo;
  wire flag_d     = flagSet | (flag_q & ~flagClear);

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  wire [15:0] rdWord =
      selCa  ? {8'h00, controlA_q} :
      selCb  ? {8'h00, controlB_q} :
      selEv  ? {8'h00, eventCtl_q} :
      selIe  ? {8'h00, intEnable_q} :
      selIf  ? {15'h0000, flag_q} :
      selSt  ? {15'h0000, running_q} :
      selDbg ? {8'h00, dbgCtl_q} :
      selBuf ? {8'h00, byteBuf_q} :
      selCnt ? count_q :
      selCmp ? compare_q : 16'h0000;

  // ----------------------------------------------------------------
  // Flip-flops
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      controlA_q  <= capture_timer_pkg::RESET_BYTE;
      controlB_q  <= capture_timer_pkg::RESET_BYTE;
      eventCtl_q  <= capture_timer_pkg::RESET_BYTE;
      intEnable_q <= capture_timer_pkg::RESET_BYTE;
      dbgCtl_q    <= capture_timer_pkg::RESET_BYTE;
      byteBuf_q   <= capture_timer_pkg::RESET_BYTE;
    end else if (wrDone && lane0) begin
      // Reserved indices match none of these selects
      if (selCa)  controlA_q  <= pwdata[7:0] & capture_timer_pkg::CONTROL_A_MASK;
      if (selCb)  controlB_q  <= pwdata[7:0] & capture_timer_pkg::CONTROL_B_MASK;
      if (selEv)  eventCtl_q  <= pwdata[7:0] & capture_timer_pkg::EVENT_CTL_MASK;
      if (selIe)  intEnable_q <= pwdata[7:0] & capture_timer_pkg::BIT0_MASK;
      if (selDbg) dbgCtl_q    <= pwdata[7:0] & capture_timer_pkg::BIT0_MASK;
      if (selBuf) byteBuf_q   <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count_q    <= capture_timer_pkg::RESET_WORD;
      compare_q  <= capture_timer_pkg::RESET_WORD;
      running_q  <= 1'b0;
      wave_q     <= 1'b0;
      div2_q     <= 1'b0;
      fpState_q  <= capture_timer_pkg::FP_WAIT_RISE;
      fpSecond_q <= 1'b0;
      trigPend_q <= 1'b0;
      flag_q     <= 1'b0;
    end else begin
      count_q    <= count_d;
      compare_q  <= compare_d;
      running_q  <= shotGo ? running_d : running_q;
      wave_q     <= shotGo ? wave_d : wave_q;
      div2_q     <= active & ~div2_q;
      fpState_q  <= fpState_d;
      fpSecond_q <= fpSecond_d;
      trigPend_q <= trigPend_d;
      flag_q     <= flag_d;
    end
  end

  // APB answer: one wait state, then pready for one cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & penable & ~pready;
      prdata  <= (psel & penable & ~pready & ~pwrite) ? {16'h0000, rdWord} : 32'h0000_0000;
      pslverr <= psel & penable & ~pready & ~mapped;
    end
  end

  // Event, interrupt and waveform outputs
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      captureEvent <= 1'b0;
      irq          <= 1'b0;
      waveOut      <= 1'b0;
    end else begin
      captureEvent <= flagSet;
      irq          <= flag_d & intEnable_q[capture_timer_pkg::FLAG_CAPTURE_BIT];
      waveOut      <= outEnable & (shotGo ? wave_d : wave_q);
    end
  end

endmodule : capture_timer

// [src/capture_timer_pkg.sv]
// Package with register map, field layout and mode codes of the capture timer
package capture_timer_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_CONTROL_A        = 8'h00;
  localparam logic [7:0] IDX_CONTROL_B        = 8'h01;
  localparam logic [7:0] IDX_RESERVED_0       = 8'h02;
  localparam logic [7:0] IDX_RESERVED_1       = 8'h03;
  localparam logic [7:0] IDX_EVENT_CONTROL    = 8'h04;
  localparam logic [7:0] IDX_INTERRUPT_ENABLE = 8'h05;
  localparam logic [7:0] IDX_INTERRUPT_FLAG   = 8'h06;
  localparam logic [7:0] IDX_RUN_STATUS       = 8'h07;
  localparam logic [7:0] IDX_DEBUG_CONTROL    = 8'h08;
  localparam logic [7:0] IDX_BYTE_BUFFER      = 8'h09;
  localparam logic [7:0] IDX_COUNTER_VALUE    = 8'h0A;
  localparam logic [7:0] IDX_COMPARE_CAPTURE  = 8'h0C;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CA_ENABLE_BIT     = 0;
  localparam int CA_CLOCK_SOURCE_SELECT_LSB     = 1;
  localparam int CA_RESTART_BIT    = 4;
  localparam int CA_STANDBY_BIT    = 6;
  localparam int CB_MODE_LSB       = 0;
  localparam int CB_OUT_EN_BIT     = 4;
  localparam int CB_OUT_INIT_BIT   = 5;
  localparam int CB_ASYNCHRONOUS_TRIGGER_BIT      = 6;
  localparam int EV_INPUT_EN_BIT   = 0;
  localparam int EV_EDGE_BIT       = 4;
  localparam int EV_FILTER_BIT     = 6;
  localparam int FLAG_CAPTURE_BIT  = 0;
  localparam int STATUS_RUN_BIT    = 0;
  localparam int DBG_RUN_BIT       = 0;

  // Writable bit masks of the 8-bit control registers
  localparam logic [7:0] CONTROL_A_MASK = 8'h57;
  localparam logic [7:0] CONTROL_B_MASK = 8'h77;
  localparam logic [7:0] EVENT_CTL_MASK = 8'h51;
  localparam logic [7:0] BIT0_MASK      = 8'h01;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  RESET_BYTE = 8'h00;
  localparam logic [15:0] RESET_WORD = 16'h0000;

  // ----------------------------------------------------------------
  // Clock source and mode encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] CLKSRC_DIV1      = 2'h0;
  localparam logic [1:0] CLKSRC_DIV2      = 2'h1;
  localparam logic [1:0] CLKSRC_COMPANION = 2'h2;

  typedef enum logic [2:0] {
    MODE_PERIODIC  = 3'b000,
    MODE_TIMEOUT   = 3'b001,
    MODE_CAPTURE   = 3'b010,
    MODE_FREQ      = 3'b011,
    MODE_PULSE     = 3'b100,
    MODE_FREQPULSE = 3'b101,
    MODE_SINGLE    = 3'b110,
    MODE_PWM8      = 3'b111
  } timer_mode_t;

  // Stages of the combined frequency and pulse-width sequence
  typedef enum logic [1:0] {
    FP_WAIT_RISE  = 2'b00,
    FP_WAIT_FALL  = 2'b01,
    FP_WAIT_RISE2 = 2'b10,
    FP_DONE       = 2'b11
  } fp_state_t;

  // Noise filter depth in samples
  localparam int FILTER_SAMPLES = 4;

endpackage : capture_timer_pkg

// [src/event_edge_sync.sv]
// Event input synchroniser with optional noise filter and edge detector
`timescale 1ns/1ps
module event_edge_sync #(
  parameter int SAMPLES = capture_timer_pkg::FILTER_SAMPLES
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // Event input and filter option
  input  wire logic eventIn,
  input  wire logic filterOn,
  // Detected edges, one cycle each
  output logic      riseEdge,
  output logic      fallEdge
);

  logic [2:0]         syncQ;
  logic [SAMPLES-1:0] histQ;
  logic               levelQ;
  logic               agreed;
  logic               stable;
  logic               newLevel;

  // ----------------------------------------------------------------
  // Three-flop synchroniser; only stages two and three are compared
  // ----------------------------------------------------------------
  assign agreed   = (syncQ[1] == syncQ[2]);
  assign stable   = (&histQ) | (~|histQ);
  assign newLevel = filterOn ? (stable ? histQ[0] : levelQ) : (agreed ? syncQ[2] : levelQ);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      syncQ    <= 3'h0;
      histQ    <= '0;
      levelQ   <= 1'b0;
      riseEdge <= 1'b0;
      fallEdge <= 1'b0;
    end else begin
      syncQ    <= {syncQ[1:0], eventIn};
      histQ    <= agreed ? {histQ[SAMPLES-2:0], syncQ[2]} : histQ;
      levelQ   <= newLevel;
      riseEdge <= newLevel & ~levelQ;
      fallEdge <= ~newLevel & levelQ;
    end
  end

endmodule : event_edge_sync

// [verification/capture_timer_props.sv]
// Port assertions of the capture timer
`timescale 1ns/1ps
module capture_timer_props (
  // Clock, reset and bus
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  // Power state and event outputs
  input wire logic        powerDownSleep,
  input wire logic        captureEvent,
  input wire logic        irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_wait; !pready ##1 pready; endsequence
  property p_wait; psel && $rose(penable) |-> s_wait; endproperty
  property p_rdy; pready |=> !pready; endproperty
  property p_err; pslverr |-> pready; endproperty
  property p_unmap; pready && paddr[9:2] == 8'h0B |-> pslverr; endproperty
  property p_resv; pready && !pwrite && paddr[9:3] == 7'h01 |-> !pslverr && prdata == 32'h0;
  endproperty
  property p_cap; captureEvent |=> !captureEvent; endproperty
  // The request may only drop through a bus access that clears or masks it
  property p_irq; $fell(irq) |-> pready || $past(pready) || $past(pready, 2); endproperty
  property p_pd; powerDownSleep && $past(powerDownSleep, 3) |-> !captureEvent; endproperty
  a_wait: assert property (p_wait) else $error("no single wait state");
  a_rdy: assert property (p_rdy) else $error("pready too long");
  a_err: assert property (p_err) else $error("pslverr without pready");
  a_unmap: assert property (p_unmap) else $error("unmapped not refused");
  a_resv: assert property (p_resv) else $error("reserved read not zero");
  a_cap: assert property (p_cap) else $error("capture event too long");
  a_irq: assert property (p_irq) else $error("irq dropped unasked");
  a_pd: assert property (p_pd) else $error("event in power-down");
endmodule : capture_timer_props

// [verification/event_partner.sv]
// Model of the companion timer and the event source
`timescale 1ns/1ps
module event_partner (
  // Clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // Stimulus from the bench
  input  wire logic tickOn,
  input  wire logic restartReq,
  input  wire logic level,
  // Signals seen by the timer
  output logic      companionTick,
  output logic      companionRestart,
  output logic      eventIn
);
  // Ticks every other cycle, like a companion prescaled by two
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) {companionTick, companionRestart, eventIn} <= 3'h0;
    else {companionTick, companionRestart, eventIn} <= {tickOn & ~companionTick, restartReq, level};
  end
endmodule : event_partner

// [verification/tb_top.sv]
// Self-checking bench of the capture timer
`timescale 1ns/1ps
module tb_top;
  logic        clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        standbySleep = 1'b0, powerDownSleep = 1'b0, debugHalt = 1'b0;
  logic        tickOn = 1'b0, restartReq = 1'b0, level = 1'b0, err;
  logic        pready, pslverr, companionTick, companionRestart, eventIn, captureEvent, waveOut, irq;
  logic [3:0]  pstrb = 4'hF;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  int          errors = 0, compares = 0, cycles = 0;
  always #5 clk = ~clk;
  capture_timer i_capture_timer (.*);
  event_partner i_event_partner (.*);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic summarize();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  // Request held until pready is seen high; the timeout ends a hang
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic evt(input logic lv, input logic exp);
    logic got;
    got = 1'b0;
    @(posedge clk);
    level <= lv;
    repeat (16) begin
      @(posedge clk);
      if (captureEvent === 1'b1) got = 1'b1;
    end
    chk({31'h0, got}, {31'h0, exp});
  endtask : evt
  task automatic t_regs();
    apb(1'b0, 8'h06, 32'h0);
    chk(q, 32'h0);
    apb(1'b1, 8'h01, 32'hFF);
    apb(1'b0, 8'h01, 32'h0);
    chk(q, 32'h77);
    apb(1'b1, 8'h03, 32'hFF);
    apb(1'b0, 8'h03, 32'h0);
    chk({q[30:0], err}, 32'h0);
    apb(1'b0, 8'h0B, 32'h0);
    chk({31'h0, err}, 32'h1);
  endtask : t_regs
  task automatic t_capture();
    apb(1'b1, 8'h01, 32'h02);
    apb(1'b1, 8'h04, 32'h01);
    apb(1'b1, 8'h05, 32'h01);
    apb(1'b1, 8'h00, 32'h01);
    evt(1'b1, 1'b1);
    chk({31'h0, irq}, 32'h1);
    apb(1'b0, 8'h06, 32'h0);
    chk(q, 32'h1);
    evt(1'b0, 1'b0);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, 8'h05, 32'h0);
    evt(1'b1, 1'b1);
    chk({31'h0, irq}, 32'h0);
    apb(1'b0, 8'h0C, 32'h0);
    apb(1'b0, 8'h06, 32'h0);
    chk(q, 32'h0);
  endtask : t_capture
  task automatic t_sleep();
    evt(1'b0, 1'b0);
    standbySleep <= 1'b1;
    evt(1'b1, 1'b0);
    apb(1'b1, 8'h00, 32'h41);
    evt(1'b0, 1'b0);
    evt(1'b1, 1'b1);
    powerDownSleep <= 1'b1;
    evt(1'b0, 1'b0);
    evt(1'b1, 1'b0);
    chk({31'h0, waveOut}, 32'h0);
  endtask : t_sleep
  // Four companion ticks, then a companion restart
  task automatic t_companion();
    powerDownSleep <= 1'b0;
    standbySleep <= 1'b0;
    apb(1'b1, 8'h01, 32'h00);
    apb(1'b1, 8'h0C, 32'hFFFF);
    // Switch to the companion clock first so the cleared count stays put
    apb(1'b1, 8'h00, 32'h15);
    apb(1'b1, 8'h0A, 32'h0);
    apb(1'b0, 8'h0A, 32'h0);
    chk(q, 32'h0);
    tickOn <= 1'b1;
    repeat (8) @(posedge clk);
    tickOn <= 1'b0;
    apb(1'b0, 8'h0A, 32'h0);
    chk(q, 32'h4);
    restartReq <= 1'b1;
    @(posedge clk);
    restartReq <= 1'b0;
    apb(1'b0, 8'h0A, 32'h0);
    chk(q, 32'h0);
  endtask : t_companion
  // Asynchronous_trigger single shot: output rises with the edge and holds for the count
  task automatic t_shot();
    apb(1'b1, 8'h00, 32'h00);
    apb(1'b1, 8'h01, 32'h56);
    apb(1'b1, 8'h0C, 32'h40);
    apb(1'b0, 8'h06, 32'h0);
    apb(1'b1, 8'h00, 32'h01);
    evt(1'b0, 1'b0);
    evt(1'b1, 1'b0);
    chk({31'h0, waveOut}, 32'h1);
    apb(1'b0, 8'h07, 32'h0);
    chk(q, 32'h1);
    repeat (80) @(posedge clk);
    chk({31'h0, waveOut}, 32'h0);
    apb(1'b0, 8'h06, 32'h0);
    chk(q, 32'h1);
  endtask : t_shot
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    t_regs();
    t_capture();
    t_sleep();
    t_companion();
    t_shot();
    summarize();
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      summarize();
    end
  end
endmodule : tb_top
bind capture_timer capture_timer_props i_capture_timer_props (.*);
